/* File: design/adctc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Write-only channel register at 0xA, low nibble
// - Single-ended: four bits pick sixteen inputs
// - Differential: three bits pick eight pairs
// - Write-only mode register at 0xB, three bits
// - Internal jumper, code zero disables everything
// - External jumper: 0/1 off, 2 DMA, 6 interrupt
// - Code one: software trigger, polled transfer
// - Code six: pacer trigger, interrupt transfer
// - Code two: pacer trigger, DMA transfer
// - Trigger stage then transfer stage per conversion
// - Pacer mode starts conversion on each tick while idle
// - Code one: any write to 0xC while idle starts one conversion
// - Ready flag sits in result high byte
// - Ready is one until conversion completes
// - Result low byte 0x4, high nibble 0x5
// - Code six: interrupt pending set per conversion, cleared 0x8
// - DMA mode issues two requests per conversion
module adctc_top
  import adctc_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Host I/O port.
  input  wire logic [ADDR_W-1:0]   io_addr,
  input  wire logic                io_wr_stb,
  input  wire logic                io_rd_stb,
  input  wire logic [DATA_W-1:0]   io_wdata,
  output logic      [DATA_W-1:0]   io_rdata,
  // Jumper straps and trigger pins.
  input  wire logic                trigger_source_jumper,
  input  wire logic                input_wiring_jumper,
  input  wire logic                ext_trigger_pin,
  input  wire logic                pacer_tick,
  // Converter.
  output logic                     conv_start,
  output logic      [CH_W-1:0]     conv_channel,
  input  wire logic                conv_done,
  input  wire logic [RES_W-1:0]    conv_result,
  // Interrupt and DMA.
  output logic                     irq_req,
  output logic                     dma_req,
  input  wire logic                dma_ack,
  output logic      [DATA_W-1:0]   dma_data
);

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  adctc_sync_if ext_if ();
  adctc_sync_if src_if ();
  adctc_sync_if wir_if ();

  adctc_pin_sync u_ext_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  (ext_trigger_pin),
    .sync    (ext_if.src)
  );

  adctc_pin_sync u_src_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  (trigger_source_jumper),
    .sync    (src_if.src)
  );

  adctc_pin_sync u_wir_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  (input_wiring_jumper),
    .sync    (wir_if.src)
  );

  // ****************************************
  // State.
  // ****************************************
  logic [CH_W-1:0]   chan_reg;
  logic [CH_W-1:0]   chan_next;
  logic [MODE_W-1:0] mode_reg;
  logic [MODE_W-1:0] mode_next;
  logic [RES_W-1:0]  result_reg;
  logic [RES_W-1:0]  result_next;
  logic              ready_reg;
  logic              ready_next;
  logic              irq_pend_reg;
  logic              irq_pend_next;
  logic              start_reg;
  logic              start_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] dma_data_reg;
  logic [DATA_W-1:0] dma_data_next;
  adctc_state_e      state_reg;
  adctc_state_e      state_next;

  // ****************************************
  // Mode decode.
  // ****************************************
  logic ext_sel;
  logic sw_en;
  logic pacer_en;
  logic ext_en;
  logic irq_en;
  logic dma_en;
  logic wr_chan;
  logic wr_mode;
  logic wr_trig;
  logic wr_clr;
  logic trig_evt;
  logic done_evt;

  always_comb begin
    ext_sel  = src_if.level;
    wr_chan  = io_wr_stb && (io_addr == OFS_CHAN);
    wr_mode  = io_wr_stb && (io_addr == OFS_MODE);
    wr_trig  = io_wr_stb && (io_addr == OFS_SWTRIG);
    wr_clr   = io_wr_stb && (io_addr == OFS_IRQ_CLR);
    // Codes not in the table leave every source and transfer disabled.
    sw_en    = !ext_sel && (mode_reg == MODE_SW_POLL);
    pacer_en = !ext_sel && ((mode_reg == MODE_TRIG_DMA) ||
                            (mode_reg == MODE_TRIG_IRQ));
    ext_en   = ext_sel && ((mode_reg == MODE_TRIG_DMA) ||
                           (mode_reg == MODE_TRIG_IRQ));
    irq_en   = (pacer_en || ext_en) && (mode_reg == MODE_TRIG_IRQ);
    dma_en   = (pacer_en || ext_en) && (mode_reg == MODE_TRIG_DMA);
    trig_evt = (sw_en && wr_trig) ||
               (pacer_en && pacer_tick) ||
               (ext_en && ext_if.rise);
    done_evt = (state_reg == ST_CONV) && conv_done;
  end

  // ****************************************
  // Registers and transfer sequence.
  // ****************************************
  always_comb begin
    chan_next     = chan_reg;
    mode_next     = mode_reg;
    result_next   = result_reg;
    ready_next    = ready_reg;
    irq_pend_next = irq_pend_reg;
    start_next    = 1'b0;
    rdata_next    = rdata_reg;
    dma_data_next = dma_data_reg;
    state_next    = state_reg;
    if (wr_chan) begin
      chan_next = io_wdata[CH_W-1:0];
    end
    if (wr_mode) begin
      mode_next = io_wdata[MODE_W-1:0];
    end
    if (wr_clr) begin
      irq_pend_next = 1'b0;
    end
    if (io_rd_stb) begin
      case (io_addr)
        OFS_RES_LO: rdata_next = result_reg[DATA_W-1:0];
        OFS_RES_HI: rdata_next = {3'h0, ready_reg, result_reg[RES_W-1:DATA_W]};
        default:    rdata_next = 8'h00;
      endcase
    end
    case (state_reg)
      ST_IDLE: begin
        if (trig_evt) begin
          start_next = 1'b1;
          ready_next = 1'b1;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        // Further triggers fall through here and are dropped.
        if (done_evt) begin
          result_next = conv_result;
          ready_next  = 1'b0;
          if (irq_en) begin
            irq_pend_next = 1'b1;
          end
          if (dma_en) begin
            dma_data_next = conv_result[DATA_W-1:0];
            state_next    = ST_DMA_LO;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_DMA_LO: begin
        if (dma_ack) begin
          dma_data_next = {4'h0, result_reg[RES_W-1:DATA_W]};
          state_next    = ST_DMA_HI;
        end
      end
      ST_DMA_HI: begin
        if (dma_ack) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_reg     <= CHAN_RST;
      mode_reg     <= MODE_RST;
      result_reg   <= RES_RST;
      ready_reg    <= READY_RST;
      irq_pend_reg <= 1'b0;
      start_reg    <= 1'b0;
      rdata_reg    <= 8'h00;
      dma_data_reg <= 8'h00;
      state_reg    <= ST_IDLE;
    end else begin
      chan_reg     <= chan_next;
      mode_reg     <= mode_next;
      result_reg   <= result_next;
      ready_reg    <= ready_next;
      irq_pend_reg <= irq_pend_next;
      start_reg    <= start_next;
      rdata_reg    <= rdata_next;
      dma_data_reg <= dma_data_next;
      state_reg    <= state_next;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  // The top select bit is forced low in differential wiring.
  assign conv_channel = wir_if.level ? {1'b0, chan_reg[CH_W-2:0]}
                                     : chan_reg;
  assign conv_start   = start_reg;
  assign io_rdata     = rdata_reg;
  assign irq_req      = irq_pend_reg;
  assign dma_req      = (state_reg == ST_DMA_LO) || (state_reg == ST_DMA_HI);
  assign dma_data     = dma_data_reg;

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence seq_conv_end;
    (state_reg == ST_CONV) && conv_done;
  endsequence

  sequence seq_low_taken;
    (state_reg == ST_DMA_LO) && dma_ack;
  endsequence

  AST_CHAN_SINGLE: assert property (!wir_if.level |-> conv_channel == chan_reg)
    else $error("single-ended channel differs from register");

  AST_CHAN_DIFF: assert property (wir_if.level |->
      (conv_channel == {1'b0, chan_reg[CH_W-2:0]}))
    else $error("differential channel not masked to three bits");

  AST_CHAN_WRITE: assert property (wr_chan |=> chan_reg == $past(io_wdata[CH_W-1:0]))
    else $error("channel write not stored");

  AST_MODE_OFF: assert property ((mode_reg == MODE_OFF) && (mode_next == MODE_OFF)
      |=> !conv_start)
    else $error("conversion started with all sources disabled");

  AST_SW_TRIG: assert property (wr_trig && sw_en && (state_reg == ST_IDLE)
      |=> conv_start && ready_reg ##1 !conv_start)
    else $error("software trigger did not give one start pulse");

  AST_PACER: assert property (pacer_tick && pacer_en && (state_reg == ST_IDLE)
      |=> conv_start)
    else $error("pacer tick did not start a conversion");

  AST_EXT_EDGE: assert property (ext_if.rise && ext_en && (state_reg == ST_IDLE)
      |=> conv_start)
    else $error("external rising edge did not start a conversion");

  AST_BUSY_DROP: assert property ((state_reg != ST_IDLE) |=> !conv_start)
    else $error("trigger accepted while busy");

  AST_READY_CLR: assert property (seq_conv_end |=> !ready_reg &&
      (result_reg == $past(conv_result)))
    else $error("ready not cleared with result on completion");

  AST_RD_HI: assert property (io_rd_stb && (io_addr == OFS_RES_HI) |=>
      io_rdata == {3'h0, $past(ready_reg), $past(result_reg[RES_W-1:DATA_W])})
    else $error("high byte read wrong");

  AST_IRQ_SET: assert property (seq_conv_end and (irq_en && !dma_en)
      |=> irq_req [*2] or (irq_req ##1 $past(wr_clr)))
    else $error("interrupt not raised after conversion");

  AST_IRQ_HOLD: assert property (irq_req && !wr_clr |=> irq_req)
    else $error("interrupt dropped without clear write");

  AST_DMA_SEQ: assert property (seq_conv_end and dma_en |=> dma_req &&
      (dma_data == result_reg[DATA_W-1:0]))
    else $error("first DMA request missing");

  AST_DMA_SECOND: assert property (seq_low_taken |=> dma_req &&
      (state_reg == ST_DMA_HI) && (dma_data == {4'h0, result_reg[RES_W-1:DATA_W]}))
    else $error("second DMA request missing");

endmodule

/* File: design/adctc_pkg.sv */
package adctc_pkg;

  // ****************************************
  // Widths.
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W  = 12;
  localparam int CH_W   = 4;
  localparam int MODE_W = 3;

  // ****************************************
  // I/O port offsets.
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_RES_LO  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RES_HI  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CHAN    = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_MODE    = 4'hb;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG  = 4'hc;

  // ****************************************
  // Field positions.
  // ****************************************
  localparam int READY_BIT = 4;
  localparam int RES_HI_W  = 4;

  // ****************************************
  // Mode codes.
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_OFF      = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SW_POLL  = 3'h1;
  localparam logic [MODE_W-1:0] MODE_TRIG_DMA = 3'h2;
  localparam logic [MODE_W-1:0] MODE_TRIG_IRQ = 3'h6;

  // ****************************************
  // Values after reset.
  // ****************************************
  localparam logic [CH_W-1:0]   CHAN_RST  = 4'h0;
  localparam logic [MODE_W-1:0] MODE_RST  = 3'h0;
  localparam logic [RES_W-1:0]  RES_RST   = 12'h000;
  localparam logic              READY_RST = 1'b1;

  typedef enum {ST_IDLE, ST_CONV, ST_DMA_LO, ST_DMA_HI} adctc_state_e;

endpackage

/* File: design/adctc_sync_if.sv */
`timescale 1ns/1ps
interface adctc_sync_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

/* File: design/adctc_pin_sync.sv */
`timescale 1ns/1ps
module adctc_pin_sync (
  // Clock and reset.
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  // Asynchronous pin.
  input  wire logic   pin_in,
  // Synchronised level and rising-edge pulse.
  adctc_sync_if.src   sync
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign sync.level = sync_reg;
  assign sync.rise  = sync_reg & ~prev_reg;

endmodule

/* File: dv/adctc_conv_model.sv */
`timescale 1ns/1ps
module adctc_conv_model
  import adctc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Converter side.
  input  wire logic             conv_start,
  input  wire logic [RES_W-1:0] res_in,
  input  wire logic [7:0]       conv_wait,
  output logic                  conv_done,
  output logic      [RES_W-1:0] conv_result,
  // DMA controller side.
  input  wire logic             dma_req,
  input  wire logic [3:0]       ack_wait,
  output logic                  dma_ack
);
  int conv_cnt;
  int ack_cnt;

  // Outside its done pulse the result bus toggles, so stale data is never valid.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      conv_cnt <= 0;
      ack_cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= '0;
      dma_ack <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      dma_ack <= 1'b0;
      if (conv_start) begin
        conv_cnt <= int'(conv_wait) + 1;
      end else if (conv_cnt == 1) begin
        conv_done <= 1'b1;
        conv_result <= res_in;
        conv_cnt <= 0;
      end else if (conv_cnt > 1) begin
        conv_cnt <= conv_cnt - 1;
      end
      if (dma_req && !dma_ack) begin
        if (ack_cnt >= int'(ack_wait)) begin
          dma_ack <= 1'b1;
          ack_cnt <= 0;
        end else begin
          ack_cnt <= ack_cnt + 1;
        end
      end
    end
  end
endmodule

/* File: dv/tb_adctc_top.sv */
`timescale 1ns/1ps
module tb_adctc_top
  import adctc_pkg::*;
;
  localparam int SETTLE_CYC = 60;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] io_addr = '0;
  logic              io_wr_stb = 1'b0;
  logic              io_rd_stb = 1'b0;
  logic [DATA_W-1:0] io_wdata = '0;
  logic [DATA_W-1:0] io_rdata;
  logic              trigger_source_jumper = 1'b0;
  logic              input_wiring_jumper = 1'b0;
  logic              ext_trigger_pin = 1'b0;
  logic              pacer_tick = 1'b0;
  logic              conv_start;
  logic [CH_W-1:0]   conv_channel;
  logic              conv_done;
  logic [RES_W-1:0]  conv_result;
  logic [RES_W-1:0]  res_in = '0;
  logic [7:0]        conv_wait = 8'h02;
  logic [3:0]        ack_wait = 4'h0;
  logic              irq_req;
  logic              dma_req;
  logic              dma_ack;
  logic [DATA_W-1:0] dma_data;
  logic [DATA_W-1:0] d;
  int                failures, cmp_count, cycles, starts, dones;
  int                mode, exp_ready, exp_res, exp_irq;
  int                dma_q[$];

  adctc_top u_adctc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .trigger_source_jumper(trigger_source_jumper), .input_wiring_jumper(input_wiring_jumper),
    .ext_trigger_pin(ext_trigger_pin), .pacer_tick(pacer_tick), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_result(conv_result),
    .irq_req(irq_req), .dma_req(dma_req), .dma_ack(dma_ack), .dma_data(dma_data));

  adctc_conv_model u_adctc_conv_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .conv_start(conv_start), .res_in(res_in), .conv_wait(conv_wait), .conv_done(conv_done),
    .conv_result(conv_result), .dma_req(dma_req), .ack_wait(ack_wait), .dma_ack(dma_ack));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (exp !== got) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = v;
    io_wr_stb = 1'b1;
    @(negedge clk_sys);
    io_wr_stb = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(negedge clk_sys);
    io_addr = a;
    io_rd_stb = 1'b1;
    @(negedge clk_sys);
    io_rd_stb = 1'b0;
    @(negedge clk_sys);
    v = io_rdata;
  endtask

  task automatic chk_regs();
    rd(OFS_RES_HI, d);
    chk("res_hi", 16'(exp_ready * 16 + exp_res / 256), 16'(d));
    rd(OFS_RES_LO, d);
    chk("res_lo", 16'(exp_res % 256), 16'(d));
    chk("irq_req", 16'(exp_irq), 16'(irq_req));
  endtask

  function automatic int trig_ok(input int kind);
    if (kind == 2) return int'(trigger_source_jumper) * int'(mode == 2 || mode == 6);
    if (kind == 1) return int'(!trigger_source_jumper) * int'(mode == 2 || mode == 6);
    return int'(!trigger_source_jumper) * int'(mode == 1);
  endfunction

  // One trigger of the given kind: 0 software, 1 pacer, 2 external pin.
  task automatic pulse(input int kind);
    if (kind == 0) begin
      wr(OFS_SWTRIG, 8'($urandom));
    end else if (kind == 1) begin
      @(negedge clk_sys);
      pacer_tick = 1'b1;
      @(negedge clk_sys);
      pacer_tick = 1'b0;
    end else begin
      @(negedge clk_sys);
      ext_trigger_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
      ext_trigger_pin = 1'b0;
    end
  endtask

  // One conversion attempt; a long conversion is hit by a second trigger of the same kind.
  task automatic fire(input int kind);
    int s0, d0, ok, n;
    res_in = 12'($urandom);
    conv_wait = 8'($urandom_range(2, 30));
    ack_wait = 4'($urandom);
    s0 = starts;
    d0 = dones;
    ok = trig_ok(kind);
    pulse(kind);
    repeat (3) @(negedge clk_sys);
    chk("start", 16'(ok), 16'(starts - s0));
    if (ok == 1) begin
      if (conv_wait >= 8'd20) begin
        rd(OFS_RES_HI, d);
        chk("busy_hi", 16'(16 + exp_res / 256), 16'(d));
        pulse(kind);
      end
      n = 0;
      while (dones == d0 && n < 200) begin
        @(negedge clk_sys);
        n++;
      end
      chk("done", 16'h1, 16'(dones - d0));
      exp_ready = 0;
      exp_res = int'(res_in);
      if (mode == 6) exp_irq = 1;
      if (mode == 2) begin
        dma_q.push_back(exp_res % 256);
        dma_q.push_back(exp_res / 256);
      end
      n = 0;
      d = 8'h10;
      while (d[READY_BIT] !== 1'b0 && n < 100) begin
        rd(OFS_RES_HI, d);
        n++;
      end
      chk("ready_poll", 16'h0, 16'(d[READY_BIT]));
      n = 0;
      while ((dma_req !== 1'b0 || dma_q.size() != 0) && n < 200) begin
        @(negedge clk_sys);
        n++;
      end
      chk("dma_req_idle", 16'h0, 16'(dma_req));
      chk("dma_left", 16'h0, 16'(dma_q.size()));
      chk("one_start", 16'h1, 16'(starts - s0));
    end
    chk_regs();
    if (exp_irq == 1) begin
      wr(OFS_IRQ_CLR, 8'($urandom));
      @(negedge clk_sys);
      exp_irq = 0;
      chk("irq_clr", 16'h0, 16'(irq_req));
    end
  endtask

  // ****************************************
  // Monitor and timeout.
  // ****************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (conv_start === 1'b1) starts++;
    if (conv_done === 1'b1) dones++;
    if (dma_req === 1'b1 && dma_ack === 1'b1) begin
      if (dma_q.size() == 0) chk("dma_extra", 16'h0, 16'h1);
      else chk("dma_data", 16'(dma_q.pop_front()), 16'(dma_data));
    end
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    void'($urandom(44));
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    exp_ready = 1;
    repeat (3) @(negedge clk_sys);
    chk_regs();
    rd(OFS_CHAN, d);
    chk("wo_read", 16'h0, 16'(d));
    for (int i = 0; i < 8; i++) begin
      input_wiring_jumper = i[0];
      wr(OFS_CHAN, 8'($urandom));
      repeat (SETTLE_CYC) @(negedge clk_sys);
      chk("chan", input_wiring_jumper ? 16'(io_wdata % 8) : 16'(io_wdata % 16),
          16'(conv_channel));
    end
    for (int j = 0; j < 2; j++) begin
      trigger_source_jumper = j[0];
      repeat (3) @(negedge clk_sys);
      for (int c = 0; c < 8; c++) begin
        mode = c;
        wr(OFS_MODE, {5'($urandom), 3'(c)});
        for (int k = 0; k < 3; k++) fire(k);
      end
    end
    trigger_source_jumper = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      mode = (i % 3 == 0) ? 1 : ((i % 3 == 1) ? 2 : 6);
      wr(OFS_MODE, 8'(mode));
      fire(mode == 1 ? 0 : 1);
    end
    final_report();
  end
endmodule
